// ==== design/pwg_core.sv ====
`default_nettype none
// ==========================================================
// PWM period and duty generator with register port
// What this block does
// - Control written zero forces output latch low
// - Period is (period+1) times four times prescale
// - Timer cleared on increment after period match
// - Rollover sets output unless duty is zero
// - Rollover copies duty byte and low bits
// - Postscaler never affects PWM period
// - Duty is byte plus control bits 5:4
// - High time is duty times oscillator times prescale
// - New duty applies only after period completes
// - Shadow register read only in PWM mode
// - Compare uses buffered duty copy only
// - Output cleared when duty equals extended timer
// - Duty beyond period keeps output high
// - Prescaler divides by one, four or sixteen
// - Period match clears timer, may raise interrupt
module pwg_core #(
   parameter int ADDR_W = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Port C direction bit of the shared pin, 1 = input
   input wire logic port_c_direction_bit,
   // Pin and interrupt
   output logic pwm_output_pin,
   output logic pwm_output_pin_oe,
   output logic irq
);
   // ==========================================================
   // Parameter check
   if (ADDR_W < 3 || ADDR_W > 4) begin : g_bad_addr
      $error("pwg_core: ADDR_W must be 3 or 4");
   end

   // ==========================================================
   // Decode helpers
   function automatic logic [3:0] ps_last(input logic [1:0] sel);
      ps_last = (sel == pwg_pkg::PS_DIV1) ? pwg_pkg::PS_LAST1 :
                (sel == pwg_pkg::PS_DIV4) ? pwg_pkg::PS_LAST4 : pwg_pkg::PS_LAST16;
   endfunction

   function automatic logic [1:0] ext_bits(input logic [1:0] sel, input logic [1:0] qv,
                                           input logic [3:0] pv);
      ext_bits = (sel == pwg_pkg::PS_DIV1) ? qv :
                 (sel == pwg_pkg::PS_DIV4) ? pv[1:0] : pv[3:2];
   endfunction

   function automatic logic is_wr(input logic wr, input logic [ADDR_W-1:0] a,
                                  input logic [3:0] ofs);
      is_wr = wr && (4'(a) == ofs);
   endfunction

   // ==========================================================
   // Registers and state
   logic [7:0] period_register;
   logic [7:0] period_timer;
   logic [7:0] timer_control;
   logic [7:0] duty_byte_register;
   logic [7:0] duty_shadow_register;
   logic [7:0] capture_compare_pwm_control;
   logic [1:0] duty_low_latch;
   logic [pwg_pkg::IRQ_W-1:0] int_status;
   logic [pwg_pkg::IRQ_W-1:0] int_mask;
   logic [1:0] q_phase;
   logic [3:0] pre_count;

   logic [1:0] next_q_phase;
   logic [3:0] next_pre_count;
   logic [7:0] next_period_timer;
   logic [1:0] next_ext;
   logic inst_tick;
   logic rollover;
   logic cmp_match;
   logic pwm_mode;
   logic tmr_on;
   logic [1:0] ps_sel;
   logic [9:0] duty_req;
   logic ctrl_wr;
   logic post_event;
   logic duty_end;
   logic [pwg_pkg::IRQ_W-1:0] irq_set;

   assign tmr_on = timer_control[pwg_pkg::TMR_ON_BIT];
   assign ps_sel = timer_control[pwg_pkg::TMR_PS_LSB +: 2];
   assign pwm_mode = capture_compare_pwm_control[pwg_pkg::CCP_MODE_LSB +: 2]
                     == pwg_pkg::CCP_MODE_PWM;
   // Requested duty: byte on top, control bits below
   assign duty_req = {duty_byte_register,
                      capture_compare_pwm_control[pwg_pkg::CCP_DLOW_LSB +: 2]};
   assign ctrl_wr = is_wr(reg_wr, reg_addr, pwg_pkg::OFS_CCP_CTRL);

   // ==========================================================
   // Time base: phase counter, prescaler, period timer
   always_comb begin
      next_q_phase = q_phase + 2'h1;
      inst_tick = (q_phase == pwg_pkg::Q_LAST) && tmr_on;
      next_pre_count = pre_count;
      next_period_timer = period_timer;
      rollover = 1'b0;
      if (inst_tick) begin
         // >= so a smaller ratio chosen mid-count cannot overrun
         if (pre_count >= ps_last(ps_sel)) begin
            next_pre_count = 4'h0;
            if (period_timer == period_register) begin
               rollover = 1'b1;
               next_period_timer = 8'h00;
            end else begin
               next_period_timer = period_timer + 8'h01;
            end
         end else begin
            next_pre_count = pre_count + 4'h1;
         end
      end
      // Undivided: phase counter; divided: prescaler bits
      next_ext = ext_bits(ps_sel, next_q_phase, next_pre_count);
      // Compared against the next position so high time is exact
      cmp_match = {duty_shadow_register, duty_low_latch} ==
                  {next_period_timer, next_ext};
   end

   // Phase counter runs freely like the instruction clock
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q_phase <= 2'h0;
      end else begin
         q_phase <= next_q_phase;
      end
   end

   // Timer and prescaler; a timer register write restarts the prescaler
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         period_timer <= pwg_pkg::RST_ZERO;
         pre_count <= 4'h0;
      end else if (is_wr(reg_wr, reg_addr, pwg_pkg::OFS_TIMER)) begin
         period_timer <= reg_wdata;
         pre_count <= 4'h0;
      end else begin
         period_timer <= next_period_timer;
         pre_count <= next_pre_count;
      end
   end

   // ==========================================================
   // Software registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         period_register <= pwg_pkg::RST_PERIOD;
         timer_control <= pwg_pkg::RST_ZERO;
         duty_byte_register <= pwg_pkg::RST_ZERO;
         capture_compare_pwm_control <= pwg_pkg::RST_ZERO;
         int_mask <= '0;
      end else if (reg_wr) begin
         // Any moment is fine; the buffer decides when it counts
         unique case (4'(reg_addr))
            pwg_pkg::OFS_PERIOD: period_register <= reg_wdata;
            pwg_pkg::OFS_TMR_CTRL: timer_control <= {1'b0, reg_wdata[6:0]};
            pwg_pkg::OFS_DUTY_BYTE: duty_byte_register <= reg_wdata;
            pwg_pkg::OFS_CCP_CTRL: capture_compare_pwm_control <=
                                   reg_wdata & pwg_pkg::CCP_CTRL_MASK;
            pwg_pkg::OFS_INT_MASK: int_mask <= reg_wdata[pwg_pkg::IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Duty double buffer, loaded only at rollover in PWM mode
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         duty_shadow_register <= pwg_pkg::RST_ZERO;
         duty_low_latch <= 2'h0;
      end else if (pwm_mode && rollover) begin
         duty_shadow_register <= duty_byte_register;
         duty_low_latch <= duty_req[1:0];
      end else if (!pwm_mode && is_wr(reg_wr, reg_addr, pwg_pkg::OFS_DUTY_SHADOW)) begin
         duty_shadow_register <= reg_wdata; // Writable outside PWM only
      end
   end

   // ==========================================================
   // Output latch
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_output_pin <= 1'b0;
      end else if (!pwm_mode || (ctrl_wr &&
                   reg_wdata[pwg_pkg::CCP_MODE_LSB +: 2] != pwg_pkg::CCP_MODE_PWM)) begin
         pwm_output_pin <= 1'b0; // Leaving PWM, including a zero write
      end else if (rollover) begin
         pwm_output_pin <= (duty_req != 10'h000);
      end else if (cmp_match) begin
         pwm_output_pin <= 1'b0; // No match past the period: stays high
      end
   end

   // Driver enable follows the port C direction bit, registered
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_output_pin_oe <= 1'b0;
      end else begin
         pwm_output_pin_oe <= !port_c_direction_bit;
      end
   end

   // ==========================================================
   // Interrupts
   pwg_postscale u_post (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .match(rollover),
      .ratio(timer_control[pwg_pkg::TMR_POST_LSB +: 4]),
      .event_pulse(post_event)
   );

   // Postscaled match only reaches the interrupt, not the period
   assign duty_end = pwm_mode && !rollover && cmp_match && pwm_output_pin;
   assign irq_set = {duty_end, post_event};

   // Sticky status, write one to clear, a new event wins
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         int_status <= '0;
      end else if (is_wr(reg_wr, reg_addr, pwg_pkg::OFS_INT_STATUS)) begin
         int_status <= (int_status & ~reg_wdata[pwg_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
         int_status <= int_status | irq_set;
      end
   end

   assign irq = |(int_status & int_mask);

   // ==========================================================
   // Read data, valid only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (4'(reg_addr))
            pwg_pkg::OFS_PERIOD: reg_rdata <= period_register;
            pwg_pkg::OFS_TIMER: reg_rdata <= period_timer;
            pwg_pkg::OFS_TMR_CTRL: reg_rdata <= timer_control;
            pwg_pkg::OFS_DUTY_BYTE: reg_rdata <= duty_byte_register;
            pwg_pkg::OFS_DUTY_SHADOW: reg_rdata <= duty_shadow_register;
            pwg_pkg::OFS_CCP_CTRL: reg_rdata <= capture_compare_pwm_control;
            pwg_pkg::OFS_INT_STATUS: reg_rdata <= {6'h00, int_status};
            pwg_pkg::OFS_INT_MASK: reg_rdata <= {6'h00, int_mask};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ==========================================================
   // Checks
   logic [15:0] gap;
   logic quiet;

   // Cycles since rollover, and whether config stayed untouched
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap <= 16'h0000;
         quiet <= 1'b0;
      end else begin
         gap <= rollover ? 16'h0000 : gap + 16'h0001;
         quiet <= reg_wr ? 1'b0 : (rollover ? 1'b1 : quiet);
      end
   end

   // Period, timer, output and buffer
   a_period_length: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rollover && quiet |-> gap + 16'h0001 == (16'(period_register) + 16'h0001)
                            * pwg_pkg::Q_PHASES * (16'(ps_last(ps_sel)) + 16'h0001))
      else $error("period length wrong");
   a_timer_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rollover && !is_wr(reg_wr, reg_addr, pwg_pkg::OFS_TIMER) |=> period_timer == 8'h00)
      else $error("timer not cleared at rollover");
   a_out_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rollover && pwm_mode && !ctrl_wr && duty_req != 10'h000 |=> pwm_output_pin)
      else $error("output not set at rollover");
   a_zero_duty: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rollover && pwm_mode && duty_req == 10'h000 |=> !pwm_output_pin)
      else $error("output set with zero duty");
   a_shadow_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rollover && pwm_mode |=> {duty_shadow_register, duty_low_latch} == $past(duty_req))
      else $error("duty not buffered at rollover");
   a_shadow_ro: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pwm_mode && !rollover && is_wr(reg_wr, reg_addr, pwg_pkg::OFS_DUTY_SHADOW)
      |=> $stable(duty_shadow_register))
      else $error("shadow written in PWM mode");
   a_ctrl_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ctrl_wr && reg_wdata == 8'h00 |=> !pwm_output_pin [*2])
      else $error("output not forced low");
   a_duty_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pwm_mode && !rollover && cmp_match |=> !pwm_output_pin)
      else $error("output not cleared at duty match");
   a_buffer_stable: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !rollover && pwm_mode |=> $stable(duty_low_latch))
      else $error("buffered duty moved mid period");

   // Time base: rollover point and prescaler restart
   a_rollover_point: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rollover |-> period_timer == period_register)
      else $error("rollover away from period value");
   a_prescale_restart: assert property (@(posedge sys_clk) disable iff (!rst_b)
      rollover |=> pre_count == 4'h0)
      else $error("prescaler not restarted at rollover");

   // Stopped timer holds; phase counter wraps after four phases
   a_timer_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !tmr_on && !is_wr(reg_wr, reg_addr, pwg_pkg::OFS_TIMER) |=> $stable(period_timer))
      else $error("stopped timer moved");
   a_phase_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
      q_phase == pwg_pkg::Q_LAST |=> q_phase == 2'h0)
      else $error("phase counter did not wrap");

   // Outside PWM the latch stays low and the low bits stay put
   a_mode_off_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !pwm_mode |=> !pwm_output_pin)
      else $error("output high outside PWM mode");
   a_low_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !pwm_mode |=> $stable(duty_low_latch))
      else $error("low duty bits moved outside PWM mode");

   // Events stick in status; driver enable tracks the direction bit
   a_event_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
      |irq_set |=> (int_status & $past(irq_set)) == $past(irq_set))
      else $error("interrupt event lost");
   a_oe_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pwm_output_pin_oe == !$past(port_c_direction_bit))
      else $error("driver enable does not follow direction bit");
endmodule
`default_nettype wire

// ==== design/pwg_pkg.sv ====
`default_nettype none
// ==========================================================
// Shared constants of the PWM period and duty generator
package pwg_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] OFS_PERIOD = 4'h0;
   localparam logic [3:0] OFS_TIMER = 4'h1;
   localparam logic [3:0] OFS_TMR_CTRL = 4'h2;
   localparam logic [3:0] OFS_DUTY_BYTE = 4'h3;
   localparam logic [3:0] OFS_DUTY_SHADOW = 4'h4;
   localparam logic [3:0] OFS_CCP_CTRL = 4'h5;
   localparam logic [3:0] OFS_INT_STATUS = 4'h6;
   localparam logic [3:0] OFS_INT_MASK = 4'h7;
   // Reset values
   localparam logic [7:0] RST_PERIOD = 8'hff;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Timer control fields
   localparam int TMR_PS_LSB = 0;
   localparam int TMR_ON_BIT = 2;
   localparam int TMR_POST_LSB = 3;
   // Capture/compare/PWM control fields
   localparam int CCP_MODE_LSB = 2;
   localparam logic [1:0] CCP_MODE_PWM = 2'h3;
   localparam int CCP_DLOW_LSB = 4;
   localparam logic [7:0] CCP_CTRL_MASK = 8'h3f;
   // Prescale selections and their last count
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV4 = 2'h1;
   localparam logic [3:0] PS_LAST1 = 4'h0;
   localparam logic [3:0] PS_LAST4 = 4'h3;
   localparam logic [3:0] PS_LAST16 = 4'hf;
   // Four oscillator phases per instruction cycle
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [15:0] Q_PHASES = 16'h0004;
   // Interrupt status bits
   localparam int IRQ_TMR_MATCH = 0;
   localparam int IRQ_DUTY_END = 1;
   localparam int IRQ_W = 2;
endpackage
`default_nettype wire

// ==== design/pwg_postscale.sv ====
`default_nettype none
// ==========================================================
// Timer match postscaler, 1:1 to 1:16
module pwg_postscale (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Match input and ratio
   input wire logic match,
   input wire logic [3:0] ratio,
   // Postscaled event
   output logic event_pulse
);
   logic [3:0] count;

   // Event on match number ratio+1 only; PWM timing never looks here
   assign event_pulse = match && (count >= ratio);

   // Match counter
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 4'h0;
      end else if (event_pulse) begin
         count <= 4'h0;
      end else if (match) begin
         count <= count + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ==== sim/pwm_period_duty_generator_tb.sv ====
`default_nettype none
// ==========================================================
// Self-checking bench for the PWM period and duty generator
module pwm_period_duty_generator_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic port_c_direction_bit = 1'b1;
   logic pwm_output_pin;
   logic pwm_output_pin_oe;
   logic irq;
   int err_count = 0;
   int checked = 0;
   logic [7:0] rv;
   int hi, per;
   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   pwg_core #(.ADDR_W(4)) pwg_core_i (
      .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .port_c_direction_bit(port_c_direction_bit), .pwm_output_pin(pwm_output_pin),
      .pwm_output_pin_oe(pwm_output_pin_oe), .irq(irq)
   );
   // ==========================================================
   // Verdict and comparison
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // ==========================================================
   // Register port cycles, one strobe cycle each
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata; // Data stands only in this cycle
   endtask
   // ==========================================================
   // Pin observation, every wait bounded
   task automatic wait_pin(input logic v);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (pwm_output_pin !== v && n < 3000);
      if (n >= 3000) begin
         err_count++;
         $display("Error at %0t: pin never reached %b", $time, v);
         report_and_stop();
      end
   endtask
   // High cycles and rise-to-rise cycles of one full period
   task automatic measure(output int h, output int p);
      wait_pin(1'b0);
      wait_pin(1'b1);
      h = 0;
      do begin
         @(posedge sys_clk);
         #1 h++;
      end while (pwm_output_pin === 1'b1 && h < 3000);
      p = h;
      do begin
         @(posedge sys_clk);
         #1 p++;
      end while (pwm_output_pin === 1'b0 && p < 3000);
   endtask
   // Counts cycles where the pin differs from a steady level
   task automatic hold_pin(input logic v, input int n, output int bad);
      bad = 0;
      repeat (n) begin
         @(posedge sys_clk);
         #1 if (pwm_output_pin !== v) bad++;
      end
   endtask
   // Stop timer, program period and duty, select PWM, start timer
   task automatic setup(input logic [7:0] p, input logic [7:0] db, input logic [1:0] lo,
                        input logic [1:0] ps, input logic [3:0] post);
      wr(pwg_pkg::OFS_TMR_CTRL, 8'h00);
      wr(pwg_pkg::OFS_PERIOD, p);
      wr(pwg_pkg::OFS_DUTY_BYTE, db);
      wr(pwg_pkg::OFS_CCP_CTRL, 8'h0c | {2'h0, lo, 4'h0});
      wr(pwg_pkg::OFS_TIMER, 8'h00);
      wr(pwg_pkg::OFS_TMR_CTRL, {1'b0, post, 1'b1, ps});
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset_regs();
      logic [7:0] exp [0:8];
      exp = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      #1 chk(pwm_output_pin, 1'b0);
      wr(4'h9, 8'h5a); // Unmapped write must vanish
      for (int i = 0; i < 9; i++) begin
         rd(i[3:0], rv);
         chk(rv, exp[i]);
      end
      rd(4'h9, rv);
      chk(rv, 8'h00);
   endtask
   // Period and high time for every prescale, postscale varied alongside
   task automatic t_timing();
      int psv;
      for (int s = 0; s < 4; s++) begin
         psv = (s == 0) ? 1 : (s == 1) ? 4 : 16;
         setup(8'h01, 8'h00, 2'h3, s[1:0], 4'(s * 7));
         measure(hi, per);
         chk(hi[15:0], 16'(3 * psv));
         chk(per[15:0], 16'(2 * 4 * psv));
      end
      setup(8'h00, 8'h00, 2'h2, pwg_pkg::PS_DIV1, 4'h0);
      measure(hi, per);
      chk(hi[15:0], 16'd2);
      chk(per[15:0], 16'd4);
      repeat (3) begin
         rd(pwg_pkg::OFS_TIMER, rv);
         chk(rv, 8'h00);
      end
   endtask
   // Duty update waits for rollover; shadow is read only in PWM mode
   task automatic t_buffer();
      setup(8'h03, 8'h01, 2'h0, pwg_pkg::PS_DIV1, 4'h0);
      wait_pin(1'b0);
      wait_pin(1'b1);
      wr(pwg_pkg::OFS_DUTY_BYTE, 8'h02);
      wr(pwg_pkg::OFS_DUTY_SHADOW, 8'haa);
      rd(pwg_pkg::OFS_DUTY_SHADOW, rv);
      chk(rv, 8'h01);
      rd(pwg_pkg::OFS_DUTY_BYTE, rv);
      chk(rv, 8'h02);
      measure(hi, per);
      chk(hi[15:0], 16'd8);
      chk(per[15:0], 16'd16);
      rd(pwg_pkg::OFS_DUTY_SHADOW, rv);
      chk(rv, 8'h02);
   endtask
   // Zero duty, duty past the period, and control cleared
   task automatic t_edges();
      int bad;
      setup(8'h01, 8'h05, 2'h0, pwg_pkg::PS_DIV1, 4'h0);
      wait_pin(1'b1);
      hold_pin(1'b1, 24, bad);
      chk(bad[15:0], 16'd0);
      wr(pwg_pkg::OFS_CCP_CTRL, 8'h00);
      #1 chk(pwm_output_pin, 1'b0);
      hold_pin(1'b0, 20, bad);
      chk(bad[15:0], 16'd0);
      setup(8'h01, 8'h00, 2'h0, pwg_pkg::PS_DIV1, 4'h0);
      hold_pin(1'b0, 40, bad);
      chk(bad[15:0], 16'd0);
   endtask
   // Match and duty-end events: sticky, masked, cleared by writing ones
   task automatic t_irq();
      // Stop the timer and clear what earlier scenarios left behind
      wr(pwg_pkg::OFS_TMR_CTRL, 8'h00);
      wr(pwg_pkg::OFS_INT_STATUS, 8'h03);
      rd(pwg_pkg::OFS_INT_STATUS, rv);
      chk(rv, 8'h00);
      setup(8'h01, 8'h00, 2'h1, pwg_pkg::PS_DIV1, 4'h0);
      repeat (20) @(posedge sys_clk);
      #1 chk(irq, 1'b0);
      rd(pwg_pkg::OFS_INT_STATUS, rv);
      chk(rv, 8'h03);
      wr(pwg_pkg::OFS_INT_MASK, 8'h02);
      #1 chk(irq, 1'b1);
      wr(pwg_pkg::OFS_TMR_CTRL, 8'h00);
      wr(pwg_pkg::OFS_INT_STATUS, 8'h02);
      #1 chk(irq, 1'b0);
      rd(pwg_pkg::OFS_INT_STATUS, rv);
      chk(rv, 8'h01);
      wr(pwg_pkg::OFS_INT_MASK, 8'h01);
      #1 chk(irq, 1'b1);
      wr(pwg_pkg::OFS_INT_STATUS, 8'h01);
      #1 chk(irq, 1'b0);
   endtask
   // Pin becomes an output only with the direction bit cleared
   task automatic t_oe();
      @(posedge sys_clk);
      port_c_direction_bit <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk(pwm_output_pin_oe, 1'b1);
      @(posedge sys_clk);
      port_c_direction_bit <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk(pwm_output_pin_oe, 1'b0);
   endtask
   // Reset in mid-run drops a high pin and empties the buffer
   task automatic t_mid_reset();
      setup(8'h01, 8'h05, 2'h0, pwg_pkg::PS_DIV1, 4'h0);
      wait_pin(1'b1);
      @(posedge sys_clk);
      rst_b <= 1'b0;
      #1 chk(pwm_output_pin, 1'b0);
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      #1 chk(pwm_output_pin, 1'b0);
      rd(pwg_pkg::OFS_DUTY_SHADOW, rv);
      chk(rv, 8'h00);
      rd(pwg_pkg::OFS_CCP_CTRL, rv);
      chk(rv, 8'h00);
      rd(pwg_pkg::OFS_PERIOD, rv);
      chk(rv, 8'hff);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset_regs();
      t_oe();
      t_timing();
      t_buffer();
      t_edges();
      t_irq();
      t_mid_reset();
      report_and_stop();
   end
endmodule
`default_nettype wire
